// ==== hw/tws_pkg.sv ====
// constants for the two-wire slave receiver: register map, bit fields, status codes
// assumes a byte-wide register port and a 40 MHz system clock
package tws_pkg;
   // =====================================================================
   // register indices
   localparam logic [1:0] REG_OWN_ADDR = 2'h0;
   localparam logic [1:0] REG_CONTROL = 2'h1;
   localparam logic [1:0] REG_STATUS = 2'h2;
   localparam logic [1:0] REG_DATA = 2'h3;
   // =====================================================================
   // serial_control bit positions
   localparam int CTL_FLAG = 7;
   localparam int CTL_ACK_EN = 6;
   localparam int CTL_START = 5;
   localparam int CTL_STOP = 4;
   localparam int CTL_WCOL = 3;
   localparam int CTL_ENABLE = 2;
   localparam int CTL_INT_EN = 0;
   // own_slave_address fields
   localparam int OWN_GCE = 0;
   localparam logic [6:0] GENERAL_CALL = 7'h00;
   // =====================================================================
   // status codes, prescaler bits zero
   localparam logic [7:0] ST_OWN_W = 8'h60;
   localparam logic [7:0] ST_ARB_OWN_W = 8'h68;
   localparam logic [7:0] ST_GC = 8'h70;
   localparam logic [7:0] ST_ARB_GC = 8'h78;
   localparam logic [7:0] ST_DATA_ACK = 8'h80;
   localparam logic [7:0] ST_DATA_NACK = 8'h88;
   localparam logic [7:0] ST_GC_DATA_ACK = 8'h90;
   localparam logic [7:0] ST_GC_DATA_NACK = 8'h98;
   localparam logic [7:0] ST_STOP_RESTART = 8'ha0;
   localparam logic [7:0] ST_NO_INFO = 8'hf8;
   localparam logic [7:0] STATUS_CODE_MASK = 8'hf8;
   localparam logic [7:0] PRESCALE_MASK = 8'h03;
   // =====================================================================
   // reset values and byte framing
   localparam logic [7:0] OWN_ADDR_RESET = 8'h00;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   typedef enum logic [2:0] {
      SL_IDLE, SL_ADDR, SL_ADDR_ACK, SL_WAIT, SL_DATA, SL_DATA_ACK, SL_IGNORE
   } tws_state_e;
endpackage

// ==== hw/tws_slave.sv ====
// two-wire slave receiver: address match, ack control, status reporting, clock stretching
// assumes SCL/SDA arrive asynchronously and a same-clock register master and power manager
//
// Contract
// - respond only when upper seven own-address bits match received address.
// - own-address bit zero set enables answering the general call 0x00.
// - own or general call address acknowledged only while ack enable set.
// - write direction enters receiver, read direction hands over to transmitter.
// - after own address with write, set flag and valid status.
// - lost arbitration then addressed for write reports 0x68 or 0x78.
// - ack enable cleared mid transfer gives nack after next byte.
// - ack enable zero ignores address, keeps watching, resumes when set.
// - system clock of interface stops in every sleep except idle.
// - clock-stopped sleep with ack enable still acks address, then wakes.
// - after wake-up hold SCL low until software clears the flag.
// - data register need not hold last bus byte after deep sleep.
// - status codes read with prescaler bits zero or masked.
// - 0x60 own address write acked; next byte ack follows ack enable.
// - 0x68 lost arbitration, own write acked; next ack follows enable.
// - 0x70 general call acked; next byte ack follows ack enable.
// - 0x78 lost arbitration, general call acked; next ack follows enable.
// - 0x80 data acked after own address; next ack follows enable.
// - 0x88 data nacked; clear with ack zero leaves not addressed, deaf.
// - not addressed with ack set keeps own, general call if enabled.
// - not addressed with start request sends start once bus free.
`timescale 1ns/1ps
`default_nettype none
module tws_slave (
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic [1:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   input wire logic SCL_IN,
   output logic SCL_OUT,
   output logic SCL_OE,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   input wire logic SLEEP_DEEP,
   input wire logic ARB_LOST,
   input wire logic BUS_FREE,
   output logic WAKE,
   output logic START_GO,
   output logic TX_SELECT
);
   import tws_pkg::*;

   // =====================================================================
   // pin synchronisers and bus conditions
   logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
   logic scl_rise, scl_fall, start_cond, stop_cond;

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_d <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_s1 <= SCL_IN;
         scl_s2 <= scl_s1;
         scl_d <= scl_s2;
         sda_s1 <= SDA_IN;
         sda_s2 <= sda_s1;
         sda_d <= sda_s2;
      end
   end

   assign scl_rise = scl_s2 & ~scl_d;
   assign scl_fall = ~scl_s2 & scl_d;
   assign start_cond = scl_s2 & scl_d & sda_d & ~sda_s2;
   assign stop_cond = scl_s2 & scl_d & ~sda_d & sda_s2;

   // =====================================================================
   // register state
   logic [7:0] own_slave_address, serial_data_reg, status_code;
   logic [1:0] prescale;
   logic interrupt_flag, acknowledge_enable, start_request, stop_request;
   logic write_collision_flag, interface_enable, interrupt_enable;
   logic reg_wr_ok, reg_rd_ok, sw_clear, hw_set, arb_seen;
   logic [7:0] hw_code;
   tws_state_e state;

   // interface clock is stopped in deep sleep, so the port is dead then
   assign reg_wr_ok = REG_WR & ~SLEEP_DEEP;
   assign reg_rd_ok = REG_RD & ~SLEEP_DEEP;
   assign sw_clear = reg_wr_ok & (REG_ADDR == REG_CONTROL) & REG_WDATA[CTL_FLAG];

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         own_slave_address <= OWN_ADDR_RESET;
         prescale <= 2'h0;
      end else if (reg_wr_ok && REG_ADDR == REG_OWN_ADDR) begin
         own_slave_address <= REG_WDATA;
      end else if (reg_wr_ok && REG_ADDR == REG_STATUS) begin
         prescale <= REG_WDATA[1:0];
      end
   end

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         acknowledge_enable <= 1'b0;
         start_request <= 1'b0;
         interface_enable <= 1'b0;
         interrupt_enable <= 1'b0;
      end else if (reg_wr_ok && REG_ADDR == REG_CONTROL) begin
         acknowledge_enable <= REG_WDATA[CTL_ACK_EN];
         start_request <= REG_WDATA[CTL_START];
         interface_enable <= REG_WDATA[CTL_ENABLE];
         interrupt_enable <= REG_WDATA[CTL_INT_EN];
      end
   end

   // stop request is self-clearing: it only aborts the current slave transfer
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         stop_request <= 1'b0;
      end else if (reg_wr_ok && REG_ADDR == REG_CONTROL) begin
         stop_request <= REG_WDATA[CTL_STOP];
      end else begin
         stop_request <= 1'b0;
      end
   end

   // hardware set wins over a clear in the same cycle
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         interrupt_flag <= 1'b0;
         status_code <= ST_NO_INFO;
      end else if (hw_set) begin
         interrupt_flag <= 1'b1;
         status_code <= hw_code;
      end else if (sw_clear) begin
         interrupt_flag <= 1'b0;
         status_code <= ST_NO_INFO;
      end
   end

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         write_collision_flag <= 1'b0;
      end else if (reg_wr_ok && REG_ADDR == REG_DATA) begin
         write_collision_flag <= ~interrupt_flag;
      end
   end

   // lost arbitration is remembered until the flag is set by hardware or the receiver returns to idle
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         arb_seen <= 1'b0;
      end else if (ARB_LOST) begin
         arb_seen <= 1'b1;
      end else if (hw_set || state == SL_IDLE) begin
         arb_seen <= 1'b0;
      end
   end

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         REG_RDATA <= ZERO_BYTE;
      end else if (reg_rd_ok) begin
         unique case (REG_ADDR)
            REG_OWN_ADDR: REG_RDATA <= own_slave_address;
            REG_CONTROL: REG_RDATA <= {interrupt_flag, acknowledge_enable, start_request,
                                       stop_request, write_collision_flag, interface_enable,
                                       1'b0, interrupt_enable};
            REG_STATUS: REG_RDATA <= (status_code & STATUS_CODE_MASK) | {6'h00, prescale};
            REG_DATA: REG_RDATA <= serial_data_reg;
         endcase
      end else begin
         REG_RDATA <= ZERO_BYTE;
      end
   end

   // =====================================================================
   // address decode
   logic [7:0] shreg;
   logic [3:0] bitcnt;
   logic own_hit, gc_hit, gc_mode, addressed;

   assign own_hit = shreg[7:1] == own_slave_address[7:1];
   assign gc_hit = (shreg[7:1] == GENERAL_CALL) & own_slave_address[OWN_GCE];
   assign addressed = (state == SL_DATA) | (state == SL_DATA_ACK);

   // =====================================================================
   // slave receiver sequencing
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state <= SL_IDLE;
         bitcnt <= 4'h0;
         shreg <= ZERO_BYTE;
         gc_mode <= 1'b0;
         SDA_OE <= 1'b0;
         hw_set <= 1'b0;
         hw_code <= ST_NO_INFO;
         TX_SELECT <= 1'b0;
      end else begin
         hw_set <= 1'b0;
         TX_SELECT <= 1'b0;
         if (!interface_enable) begin
            state <= SL_IDLE;
            SDA_OE <= 1'b0;
         end else if ((start_cond || stop_cond) && state != SL_WAIT) begin
            // a condition in the middle of our transfer ends it
            SDA_OE <= 1'b0;
            bitcnt <= 4'h0;
            state <= start_cond ? SL_ADDR : SL_IDLE;
            if (addressed) begin
               hw_set <= 1'b1;
               hw_code <= ST_STOP_RESTART;
            end
         end else if (scl_rise && (state == SL_ADDR || state == SL_DATA)) begin
            shreg <= {shreg[6:0], sda_s2};
            bitcnt <= bitcnt + 4'h1;
         end else if (scl_fall) begin
            unique case (state)
               SL_ADDR: begin
                  if (bitcnt == BITS_PER_BYTE) begin
                     // monitoring goes on while ack is off; resumes when set
                     if ((own_hit || gc_hit) && acknowledge_enable) begin
                        if (!shreg[0]) begin
                           SDA_OE <= 1'b1;
                           gc_mode <= gc_hit & ~own_hit;
                           state <= SL_ADDR_ACK;
                        end else begin
                           TX_SELECT <= own_hit;
                           state <= SL_IGNORE;
                        end
                     end else begin
                        state <= SL_IGNORE;
                     end
                  end
               end
               SL_ADDR_ACK: begin
                  SDA_OE <= 1'b0;
                  hw_set <= 1'b1;
                  state <= SL_WAIT;
                  if (gc_mode) begin
                     hw_code <= arb_seen ? ST_ARB_GC : ST_GC;
                  end else begin
                     hw_code <= arb_seen ? ST_ARB_OWN_W : ST_OWN_W;
                  end
               end
               SL_DATA: begin
                  if (bitcnt == BITS_PER_BYTE) begin
                     // ack enable sampled at the byte end, so a late clear still nacks
                     SDA_OE <= acknowledge_enable;
                     state <= SL_DATA_ACK;
                  end
               end
               SL_DATA_ACK: begin
                  SDA_OE <= 1'b0;
                  hw_set <= 1'b1;
                  state <= SL_WAIT;
                  if (gc_mode) begin
                     hw_code <= SDA_OE ? ST_GC_DATA_ACK : ST_GC_DATA_NACK;
                  end else begin
                     hw_code <= SDA_OE ? ST_DATA_ACK : ST_DATA_NACK;
                  end
               end
               default: begin
               end
            endcase
         end else if (state == SL_WAIT && sw_clear) begin
            bitcnt <= 4'h0;
            // stop register only updates on this edge, so read the strobe's own bit
            if (status_code == ST_DATA_NACK || status_code == ST_GC_DATA_NACK ||
                status_code == ST_STOP_RESTART || REG_WDATA[CTL_STOP]) begin
               state <= SL_IDLE;
            end else begin
               state <= SL_DATA;
            end
         end
      end
   end

   // received byte is not kept while the interface clock is stopped
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         serial_data_reg <= ZERO_BYTE;
      end else if (reg_wr_ok && REG_ADDR == REG_DATA && interrupt_flag) begin
         serial_data_reg <= REG_WDATA;
      end else if (state == SL_DATA && scl_fall && bitcnt == BITS_PER_BYTE && !SLEEP_DEEP) begin
         serial_data_reg <= shreg;
      end
   end

   // =====================================================================
   // clock stretch, wake-up and pending start
   logic start_pending;

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         SCL_OE <= 1'b0;
      end else begin
         // long wake-up holds the whole bus; that is the price of not losing the byte
         SCL_OE <= (state == SL_WAIT) & ~sw_clear;
      end
   end

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         WAKE <= 1'b0;
      end else begin
         WAKE <= SLEEP_DEEP & (interrupt_flag | hw_set);
      end
   end

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         start_pending <= 1'b0;
         START_GO <= 1'b0;
      end else begin
         START_GO <= 1'b0;
         if (state == SL_WAIT && sw_clear && REG_WDATA[CTL_START] &&
             (status_code == ST_DATA_NACK || status_code == ST_GC_DATA_NACK ||
              status_code == ST_STOP_RESTART)) begin
            start_pending <= 1'b1;
         end else if (start_pending && BUS_FREE) begin
            start_pending <= 1'b0;
            START_GO <= 1'b1;
         end
      end
   end

   // open-drain pins only ever pull low
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         SCL_OUT <= 1'b0;
         SDA_OUT <= 1'b0;
      end else begin
         SCL_OUT <= 1'b0;
         SDA_OUT <= 1'b0;
      end
   end

   // =====================================================================
   // checks
   sequence s_addr_done;
      state == SL_ADDR_ACK && scl_fall;
   endsequence
   sequence s_flag_up;
      ##1 hw_set ##1 interrupt_flag;
   endsequence

   property p_ack_needs_match;
      @(posedge CLOCK) disable iff (SYS_RST)
      $rose(state == SL_ADDR_ACK) |-> SDA_OE && acknowledge_enable && !shreg[0]
         && (own_hit || gc_hit);
   endproperty
   a_ack_needs_match: assert property (p_ack_needs_match) else $error("address ack without match");

   property p_gc_gated;
      @(posedge CLOCK) disable iff (SYS_RST)
      $rose(state == SL_ADDR_ACK) && gc_mode |-> own_slave_address[OWN_GCE];
   endproperty
   a_gc_gated: assert property (p_gc_gated) else $error("general call acked while disabled");

   property p_flag_after_addr;
      @(posedge CLOCK) disable iff (SYS_RST)
      s_addr_done |-> s_flag_up;
   endproperty
   a_flag_after_addr: assert property (p_flag_after_addr) else $error("no flag after address");

   property p_addr_code;
      @(posedge CLOCK) disable iff (SYS_RST)
      s_addr_done and arb_seen and !gc_mode |-> ##2 status_code == ST_ARB_OWN_W;
   endproperty
   a_addr_code: assert property (p_addr_code) else $error("lost arbitration code wrong");

   property p_nack_follows_enable;
      @(posedge CLOCK) disable iff (SYS_RST)
      state == SL_DATA && scl_fall && bitcnt == BITS_PER_BYTE && interface_enable
         && !start_cond && !stop_cond |=> SDA_OE == $past(acknowledge_enable);
   endproperty
   a_nack_follows_enable: assert property (p_nack_follows_enable) else $error("data ack wrong");

   property p_stretch;
      @(posedge CLOCK) disable iff (SYS_RST)
      state == SL_WAIT && !sw_clear |=> SCL_OE;
   endproperty
   a_stretch: assert property (p_stretch) else $error("SCL not held while waiting");

   property p_wake;
      @(posedge CLOCK) disable iff (SYS_RST)
      SLEEP_DEEP && interrupt_flag |=> WAKE;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake on flag in sleep");

   property p_sleep_port_dead;
      @(posedge CLOCK) disable iff (SYS_RST)
      SLEEP_DEEP && REG_RD |=> REG_RDATA == ZERO_BYTE;
   endproperty
   a_sleep_port_dead: assert property (p_sleep_port_dead) else $error("port live in sleep");

   property p_nack_release;
      @(posedge CLOCK) disable iff (SYS_RST)
      state == SL_WAIT && sw_clear && status_code == ST_DATA_NACK && interface_enable
         |=> state == SL_IDLE;
   endproperty
   a_nack_release: assert property (p_nack_release) else $error("still addressed after nack");

   property p_start_go;
      @(posedge CLOCK) disable iff (SYS_RST)
      start_pending && BUS_FREE |=> START_GO && !start_pending;
   endproperty
   a_start_go: assert property (p_start_go) else $error("pending start not issued");
endmodule
`default_nettype wire

// ==== tb/tws_master_model.sv ====
// bus master transmitter model: start, stop, bytes out with the ack sampled back
// assumes the bench resolves the open-drain wires with pull-ups
`timescale 1ns/1ps
`default_nettype none
module tws_master_model (
   input wire logic scl_line,
   input wire logic sda_line,
   output logic scl_low,
   output logic sda_low
);
   localparam time HALF = 100;
   localparam time HOLD = 50;
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   // ==========
   // bit level
   // data moves only while the clock is low; the slave may stretch the low phase
   task automatic clock_bit(input logic b, output logic s);
      sda_low = ~b;
      #HALF;
      scl_low = 1'b0;
      wait (scl_line);
      #HALF;
      s = sda_line;
      scl_low = 1'b1;
      #HOLD;
   endtask
   task automatic start_cond();
      sda_low = 1'b0;
      #HALF;
      scl_low = 1'b0;
      wait (scl_line);
      #HALF;
      sda_low = 1'b1;
      #HALF;
      scl_low = 1'b1;
      #HOLD;
   endtask
   task automatic stop_cond();
      sda_low = 1'b1;
      #HALF;
      scl_low = 1'b0;
      wait (scl_line);
      #HALF;
      sda_low = 1'b0;
      #HALF;
   endtask
   // ==========
   // byte level, msb first
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clock_bit(b[i], s);
      end
      clock_bit(1'b1, s);
      ack = ~s;
      // long low after the ack so the slave can start stretching first
      #HALF;
   endtask
endmodule
`default_nettype wire

// ==== tb/tws_slave_bench.sv ====
// self-checking bench for the two-wire slave receiver with a master model
// assumes tws_pkg, tws_slave and tws_master_model are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module tws_slave_bench;
   import tws_pkg::*;
   typedef struct packed {
      logic [7:0] own;
      logic [7:0] ctl;
      logic arb;
      logic [7:0] addr;
      logic ack;
      logic [7:0] status;
      logic tx;
   } tws_row_s;
   logic clock, sys_rst, reg_wr, reg_rd, sleep_deep, arb_lost, bus_free;
   logic [1:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rd;
   logic scl_out, scl_oe, sda_out, sda_oe, wake, start_go, tx_select, scl_low, sda_low, ack;
   int n_mismatch = 0;
   int n_compared = 0;
   int cycles = 0;
   int tx_count = 0;
   int go_count = 0;
   int tx_start, go_before;
   tws_row_s rows [8];
   wire scl_line = ~(scl_low | (scl_oe & ~scl_out));
   wire sda_line = ~(sda_low | (sda_oe & ~sda_out));
   tws_slave tws_slave_inst (
      .CLOCK(clock), .SYS_RST(sys_rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .SCL_IN(scl_line),
      .SCL_OUT(scl_out), .SCL_OE(scl_oe), .SDA_IN(sda_line), .SDA_OUT(sda_out),
      .SDA_OE(sda_oe), .SLEEP_DEEP(sleep_deep), .ARB_LOST(arb_lost), .BUS_FREE(bus_free),
      .WAKE(wake), .START_GO(start_go), .TX_SELECT(tx_select));
   tws_master_model tws_master_model_inst (
      .scl_line(scl_line), .sda_line(sda_line), .scl_low(scl_low), .sda_low(sda_low));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // ==========
   // pulse counters and hang guard
   always @(posedge clock) begin
      cycles++;
      if (tx_select === 1'b1) tx_count++;
      if (start_go === 1'b1) go_count++;
      if (cycles == 40000) begin
         n_mismatch++;
         final_report();
      end
   end
   // ==========
   // register port and helpers
   task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task automatic chk_status(input logic [7:0] e);
      reg_read(REG_STATUS, rd);
      `CHK(rd & STATUS_CODE_MASK, e)
   endtask
   task automatic wait_stretch();
      repeat (40) if (scl_oe !== 1'b1) @(posedge clock);
      repeat (2) @(posedge clock);
   endtask
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      {sys_rst, reg_wr, reg_rd, sleep_deep, arb_lost, bus_free} = 6'h20;
      reg_addr = 2'h0;
      reg_wdata = 8'h00;
      rows = '{'{8'ha4, 8'h44, 1'b0, 8'ha4, 1'b1, ST_OWN_W, 1'b0},
               '{8'ha4, 8'h44, 1'b0, 8'ha6, 1'b0, ST_NO_INFO, 1'b0},
               '{8'ha4, 8'h44, 1'b0, 8'h00, 1'b0, ST_NO_INFO, 1'b0},
               '{8'ha5, 8'h44, 1'b0, 8'h00, 1'b1, ST_GC, 1'b0},
               '{8'ha4, 8'h04, 1'b0, 8'ha4, 1'b0, ST_NO_INFO, 1'b0},
               '{8'ha4, 8'h44, 1'b1, 8'ha4, 1'b1, ST_ARB_OWN_W, 1'b0},
               '{8'ha5, 8'h44, 1'b1, 8'h00, 1'b1, ST_ARB_GC, 1'b0},
               '{8'ha4, 8'h44, 1'b0, 8'ha5, 1'b0, ST_NO_INFO, 1'b1}};
      repeat (8) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clock);
      reg_read(REG_OWN_ADDR, rd);
      `CHK(rd, OWN_ADDR_RESET)
      reg_read(REG_CONTROL, rd);
      `CHK(rd, ZERO_BYTE)
      chk_status(ST_NO_INFO);
      // data write with no flag pending collides
      reg_write(REG_DATA, 8'h5a);
      reg_read(REG_CONTROL, rd);
      `CHK(rd[CTL_WCOL], 1'b1)
      // prescaler bits read back beside the code
      reg_write(REG_STATUS, PRESCALE_MASK);
      reg_read(REG_STATUS, rd);
      `CHK(rd, ST_NO_INFO | PRESCALE_MASK)
      // ==========
      // address decisions
      foreach (rows[i]) begin
         reg_write(REG_OWN_ADDR, rows[i].own);
         reg_write(REG_CONTROL, rows[i].ctl);
         tx_start = tx_count;
         tws_master_model_inst.start_cond();
         if (rows[i].arb) begin
            @(posedge clock) arb_lost <= 1'b1;
            @(posedge clock) arb_lost <= 1'b0;
         end
         tws_master_model_inst.send_byte(rows[i].addr, ack);
         `CHK(ack, rows[i].ack)
         if (rows[i].ack) wait_stretch();
         else repeat (10) @(posedge clock);
         chk_status(rows[i].status);
         `CHK(tx_count != tx_start, rows[i].tx)
         reg_write(REG_CONTROL, 8'h94);
         tws_master_model_inst.stop_cond();
      end
      // ==========
      // data bytes: stretch, ack, late ack clear, nack, start request
      reg_write(REG_CONTROL, 8'h44);
      tws_master_model_inst.start_cond();
      tws_master_model_inst.send_byte(8'ha4, ack);
      wait_stretch();
      fork
         tws_master_model_inst.send_byte(8'h3c, ack);
         begin
            repeat (30) @(posedge clock);
            `CHK(scl_oe, 1'b1)
            reg_write(REG_CONTROL, 8'hc4);
         end
      join
      `CHK(ack, 1'b1)
      wait_stretch();
      chk_status(ST_DATA_ACK);
      reg_read(REG_DATA, rd);
      `CHK(rd, 8'h3c)
      reg_write(REG_CONTROL, 8'h84);
      tws_master_model_inst.send_byte(8'h5a, ack);
      `CHK(ack, 1'b0)
      wait_stretch();
      chk_status(ST_DATA_NACK);
      go_before = go_count;
      reg_write(REG_CONTROL, 8'ha4);
      repeat (10) @(posedge clock);
      `CHK(go_count == go_before, 1'b1)
      @(posedge clock) bus_free <= 1'b1;
      repeat (10) @(posedge clock);
      `CHK(go_count == go_before + 1, 1'b1)
      @(posedge clock) bus_free <= 1'b0;
      tws_master_model_inst.stop_cond();
      tws_master_model_inst.start_cond();
      tws_master_model_inst.send_byte(8'ha4, ack);
      `CHK(ack, 1'b0)
      tws_master_model_inst.stop_cond();
      // ==========
      // clock-stopped sleep: address ack, wake, hold until cleared
      reg_write(REG_CONTROL, 8'h44);
      @(posedge clock) sleep_deep <= 1'b1;
      tws_master_model_inst.start_cond();
      tws_master_model_inst.send_byte(8'ha4, ack);
      `CHK(ack, 1'b1)
      wait_stretch();
      `CHK(wake, 1'b1)
      reg_read(REG_OWN_ADDR, rd);
      `CHK(rd, ZERO_BYTE)
      repeat (20) @(posedge clock);
      `CHK(scl_oe, 1'b1)
      @(posedge clock) sleep_deep <= 1'b0;
      reg_write(REG_CONTROL, 8'h94);
      repeat (2) @(posedge clock);
      `CHK(scl_oe, 1'b0)
      tws_master_model_inst.stop_cond();
      // ==========
      // general call data byte, then reset in mid-run while stretching
      reg_write(REG_OWN_ADDR, 8'ha5);
      reg_write(REG_CONTROL, 8'h44);
      tws_master_model_inst.start_cond();
      tws_master_model_inst.send_byte(8'h00, ack);
      wait_stretch();
      reg_write(REG_CONTROL, 8'hc4);
      tws_master_model_inst.send_byte(8'h81, ack);
      `CHK(ack, 1'b1)
      wait_stretch();
      chk_status(ST_GC_DATA_ACK);
      @(posedge clock) sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      reg_read(REG_STATUS, rd);
      `CHK(rd, ST_NO_INFO)
      reg_read(REG_OWN_ADDR, rd);
      `CHK(rd, OWN_ADDR_RESET)
      `CHK({scl_oe, scl_out, sda_oe, sda_out}, 4'h0)
      tws_master_model_inst.stop_cond();
      final_report();
   end
endmodule
`default_nettype wire
